// ### rtl/spd_pkg.sv
/*
 * Shared constants and state types of the presence-detect EEPROM slave.
 * Assumes a 250 MHz system clock for all derived cycle counts.
 */
`default_nettype none

package spd_pkg;

	// Internal program cycle after a write, in milliseconds, and its cycle count.
	localparam int T_WRC_MS = 10;
	localparam int CLK_SYS_MHZ = 250;
	localparam int WRC_CYC = T_WRC_MS * 1000 * CLK_SYS_MHZ;

	// Array geometry and page size.
	localparam int MEM_BYTES_DEF = 256;
	localparam int PAGE_BYTES_DEF = 16;

	// Bit counter marks within one byte on the link.
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_DONE = 4'h8;

	// Reset value of the protection register.
	localparam logic [7:0] PROT_RST = 8'h00;

	// Device type identifiers; the values are arbitrary.
	localparam logic [3:0] ID_ARRAY_DEF = 4'h5;
	localparam logic [3:0] ID_PROT_DEF = 4'h9;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_ACK = 5'h04,
		ST_TX = 5'h08,
		ST_TXACK = 5'h10
	} link_state_e;

	typedef enum logic [2:0] {
		K_DEV = 3'h1,
		K_ADDR = 3'h2,
		K_DATA = 3'h4
	} rx_kind_e;

endpackage

`default_nettype wire

// ### rtl/spd_eeprom_slave.sv
/*
 * Two-wire serial slave of a presence-detect EEPROM: start/stop detection,
 * select decoding against three straps, byte/page write and all reads.
 * Assumes SCL is the link clock port (may stop between frames), SDA is
 * open drain resolved outside, and straps and write control are static.
 */
// Functional notes
// [R1] SDA is changed only while SCL is low; high-phase changes mean start or stop.
// [R2] Start is SDA falling while SCL high; it precedes every command.
// [R3] Bus activity is ignored until a start is seen.
// [R4] Stop is SDA rising while SCL high; it ends every transfer.
// [R5] A stop puts the slave into standby.
// [R6] After eight bits the sender releases SDA.
// [R7] The receiver acknowledges each byte by holding SDA low on clock nine.
// [R8] Start plus matching select byte is acknowledged unless a program cycle is running.
// [R9] When selected for write, every further byte is acknowledged.
// [R10] Reads shift eight bits, release SDA, then sample the master acknowledge.
// [R11] Master acknowledge without stop makes the slave send the next byte.
// [R12] Master no-acknowledge stops sending; slave waits for stop, then standby.
// [R13] Select byte MSB first: type b7-b4, straps b3-b1, read flag b0.
// [R14] Two type identifiers select the array or the protection register.
// [R15] Current address read returns the byte at the current address.
// [R16] Random read: write select, word address, restart, read select.
// [R17] Sequential read keeps returning successive bytes while acknowledged.
// [R18] Writes take effect only with write control low; page holds 16 bytes.
// [R19] After a write stop, a program cycle of up to 10 ms blocks acknowledge.
// [R20] Wrong identifier or straps: no acknowledge, rest of transfer ignored.
// [R21] Internal address increments after every byte read or written.
`default_nettype none

module spd_eeprom_slave
	import spd_pkg::*;
#(
	parameter int WRITE_CYCLE_CYC = WRC_CYC,
	parameter int MEM_BYTES = MEM_BYTES_DEF,
	parameter int PAGE_BYTES = PAGE_BYTES_DEF,
	parameter logic [3:0] ID_ARRAY = ID_ARRAY_DEF,
	parameter logic [3:0] ID_PROT = ID_PROT_DEF
)
(
	// System clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// Two-wire link
	input wire logic LINK_SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	// Straps and write control
	input wire logic WRITE_CTRL_N_I,
	input wire logic MODULE_ADDR_STRAP_2_I,
	input wire logic MODULE_ADDR_STRAP_1_I,
	input wire logic MODULE_ADDR_STRAP_0_I,
	// Status
	output logic STANDBY_O,
	output logic PROG_BUSY_O
);

	localparam int AW = $clog2(MEM_BYTES);
	localparam int PW = $clog2(PAGE_BYTES);
	localparam int CW = $clog2(WRITE_CYCLE_CYC + 1);

	logic link_rst_a;
	logic link_rst_n;
	logic sda_rise;
	logic [3:0] pin_a;
	logic [3:0] pin_l;
	logic busy_a;
	logic busy_l;
	link_state_e state;
	rx_kind_e kind;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic [AW-1:0] addr;
	logic rw;
	logic sel_prot;
	logic oe;
	logic dirty;
	logic [7:0] prot_reg;
	logic [7:0] mem [MEM_BYTES];
	logic scl_a;
	logic scl_s;
	logic scl_d;
	logic sda_a;
	logic sda_s;
	logic sda_d;
	logic dirty_a;
	logic dirty_s;
	logic busy;
	logic [CW-1:0] busy_cnt;

	// Page writes wrap inside the page, reads run through the whole array.
	function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic wrap);
		logic [AW-1:0] inc;
		inc = a + 1'b1;
		step = wrap ? {a[AW-1:PW], inc[PW-1:0]} : inc;
	endfunction

	// The link logic only sees SCL edges, so its reset release waits for SCL to run.
	always_ff @(negedge LINK_SCL_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			link_rst_a <= 1'b0;
			link_rst_n <= 1'b0;
		end
		else
		begin
			link_rst_a <= 1'b1;
			link_rst_n <= link_rst_a;
		end
	end

	// SDA is timed to SCL by the protocol, so it is sampled straight on SCL edges.
	always_ff @(posedge LINK_SCL_I or negedge link_rst_n)
	begin
		if (!link_rst_n)
			sda_rise <= 1'b1;
		else
			sda_rise <= SDA_I;
	end

	always_ff @(negedge LINK_SCL_I or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			pin_a <= 4'hf;
			pin_l <= 4'hf;
			busy_a <= 1'b0;
			busy_l <= 1'b0;
		end
		else
		begin
			pin_a <= {WRITE_CTRL_N_I, MODULE_ADDR_STRAP_2_I, MODULE_ADDR_STRAP_1_I,
				MODULE_ADDR_STRAP_0_I};
			pin_l <= pin_a;
			busy_a <= busy;
			busy_l <= busy_a;
		end
	end

	wire logic start_det = sda_rise & ~SDA_I; // [R2]
	wire logic stop_det = ~sda_rise & SDA_I; // [R4]
	wire logic quiet = ~start_det & ~stop_det;
	wire logic [7:0] byte_in = {sh[6:0], sda_rise}; // [R13]
	wire logic type_arr = byte_in[7:4] == ID_ARRAY;
	wire logic type_prot = byte_in[7:4] == ID_PROT;
	wire logic dev_hit = (type_arr | type_prot) & (byte_in[3:1] == pin_l[2:0]); // [R14]
	wire logic write_ok = ~pin_l[3]; // [R18]
	wire logic rx_last = (state == ST_RX) && (cnt == BIT_LAST) && quiet;
	wire logic mem_we = rx_last && (kind == K_DATA) && write_ok && !sel_prot;
	wire logic [7:0] rd_byte = sel_prot ? prot_reg : mem[addr]; // [R15]

	always_ff @(negedge LINK_SCL_I)
	begin
		if (mem_we)
			mem[addr] <= byte_in; // [R18]
	end

	// All link outputs move on the SCL falling edge, i.e. while SCL is low.
	always_ff @(negedge LINK_SCL_I or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			state <= ST_IDLE;
			kind <= K_DEV;
			cnt <= BIT_FIRST;
			sh <= 8'h00;
			addr <= '0;
			rw <= 1'b0;
			sel_prot <= 1'b0;
			oe <= 1'b0;
			dirty <= 1'b0;
			prot_reg <= PROT_RST;
		end
		else if (start_det) // [R2] [R3] [R16]
		begin
			state <= ST_RX;
			kind <= K_DEV;
			cnt <= BIT_FIRST;
			oe <= 1'b0;
			dirty <= 1'b0;
		end
		else if (stop_det) // [R4]
		begin
			state <= ST_IDLE;
			oe <= 1'b0;
		end
		else
		begin
			case (state)
				ST_RX:
				begin
					sh <= byte_in;
					cnt <= 4'(cnt + 4'h1);
					if (cnt == BIT_LAST)
					begin
						cnt <= BIT_FIRST;
						if (kind == K_DEV)
						begin
							if (dev_hit && !busy_l) // [R8] [R19]
							begin
								state <= ST_ACK;
								oe <= 1'b1; // [R7]
								rw <= byte_in[0];
								sel_prot <= type_prot;
							end
							else
								state <= ST_IDLE; // [R20]
						end
						else
						begin
							state <= ST_ACK;
							oe <= 1'b1; // [R9]
							if (kind == K_ADDR)
								addr <= byte_in[AW-1:0];
							else if (write_ok)
							begin
								addr <= step(addr, 1'b1); // [R21]
								dirty <= 1'b1;
								if (sel_prot)
									prot_reg <= byte_in;
							end
						end
					end
				end
				ST_ACK:
				begin
					if (rw)
					begin
						state <= ST_TX; // [R15]
						oe <= ~rd_byte[7];
						sh <= {rd_byte[6:0], 1'b0};
						cnt <= 4'h1;
						addr <= step(addr, 1'b0); // [R21]
					end
					else
					begin
						state <= ST_RX;
						oe <= 1'b0; // [R6]
						kind <= (kind == K_DEV) ? K_ADDR : K_DATA;
					end
				end
				ST_TX:
				begin
					if (cnt == BIT_DONE)
					begin
						state <= ST_TXACK;
						oe <= 1'b0; // [R6] [R10]
					end
					else
					begin
						oe <= ~sh[7]; // [R1]
						sh <= {sh[6:0], 1'b0};
						cnt <= 4'(cnt + 4'h1);
					end
				end
				ST_TXACK:
				begin
					if (!sda_rise) // [R11] [R17]
					begin
						state <= ST_TX;
						oe <= ~rd_byte[7];
						sh <= {rd_byte[6:0], 1'b0};
						cnt <= 4'h1;
						addr <= step(addr, 1'b0);
					end
					else
						state <= ST_IDLE; // [R12]
				end
				default:
				begin
					state <= ST_IDLE;
					oe <= 1'b0;
				end
			endcase
		end
	end

	assign SDA_O = 1'b0;
	assign SDA_OE_O = oe;

	// System side: watches the pins for stop/start and times the program cycle.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			{scl_a, scl_s, scl_d} <= 3'h7;
			{sda_a, sda_s, sda_d} <= 3'h7;
			{dirty_a, dirty_s} <= 2'h0;
		end
		else
		begin
			{scl_a, scl_s, scl_d} <= {LINK_SCL_I, scl_a, scl_s};
			{sda_a, sda_s, sda_d} <= {SDA_I, sda_a, sda_s};
			{dirty_a, dirty_s} <= {dirty, dirty_a};
		end
	end

	wire logic sys_stop = scl_s & scl_d & sda_s & ~sda_d;
	wire logic sys_start = scl_s & scl_d & ~sda_s & sda_d;
	wire logic prog_go = sys_stop & dirty_s & ~busy;

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			STANDBY_O <= 1'b1;
		else if (sys_stop)
			STANDBY_O <= 1'b1; // [R5] [R12]
		else if (sys_start)
			STANDBY_O <= 1'b0;
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			busy <= 1'b0;
			busy_cnt <= '0;
		end
		else if (prog_go)
		begin
			busy <= 1'b1; // [R19]
			busy_cnt <= CW'(WRITE_CYCLE_CYC - 1);
		end
		else if (busy)
		begin
			busy <= busy_cnt != '0;
			busy_cnt <= busy_cnt - 1'b1;
		end
	end

	assign PROG_BUSY_O = busy;

	property p_start_rx;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		start_det |=> state == ST_RX && kind == K_DEV && cnt == BIT_FIRST && !oe;
	endproperty
	a_start_rx: assert property (p_start_rx) else $error("start not taken"); // [R2]

	property p_idle_quiet;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		state == ST_IDLE && !start_det |=> state == ST_IDLE && !oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle slave acted"); // [R3]

	property p_stop_idle;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		stop_det && !start_det |=> state == ST_IDLE && !oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured"); // [R4]

	property p_dev_ack;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		rx_last && kind == K_DEV && dev_hit && !busy_l |=> oe ##1 !oe || state == ST_TX;
	endproperty
	a_dev_ack: assert property (p_dev_ack) else $error("select not acked"); // [R8]

	property p_nomatch;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		rx_last && kind == K_DEV && (!dev_hit || busy_l) |=> !oe && state == ST_IDLE;
	endproperty
	a_nomatch: assert property (p_nomatch) else $error("foreign select acked"); // [R20]

	property p_wr_ack;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		rx_last && kind != K_DEV |=> oe && state == ST_ACK;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked"); // [R9]

	property p_tx_release;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		state == ST_TX && cnt == BIT_DONE && quiet |=> !oe && state == ST_TXACK;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("SDA held after byte"); // [R10]

	property p_read_next;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		state == ST_TXACK && !sda_rise && quiet |=> state == ST_TX && cnt == 4'h1
			&& addr == step($past(addr), 1'b0);
	endproperty
	a_read_next: assert property (p_read_next) else $error("no next byte"); // [R11]

	property p_nack_idle;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		state == ST_TXACK && sda_rise && quiet |=> state == ST_IDLE && !oe;
	endproperty
	a_nack_idle: assert property (p_nack_idle) else $error("sent after nack"); // [R12]

	property p_wc_block;
		@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		rx_last && kind == K_DATA && !write_ok |=> $stable(prot_reg) && $stable(addr);
	endproperty
	a_wc_block: assert property (p_wc_block) else $error("write while protected"); // [R18]

	property p_prog_len;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		prog_go |=> busy && busy_cnt == CW'(WRITE_CYCLE_CYC - 1);
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program cycle wrong"); // [R19]

	property p_standby;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		sys_stop |=> STANDBY_O ##1 STANDBY_O || sys_start;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby on stop"); // [R5]

	c_seq_read: cover property (@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		state == ST_TXACK && !sda_rise ##1 state == ST_TX);
	c_write: cover property (@(negedge LINK_SCL_I) disable iff (!link_rst_n) mem_we);
	c_nomatch: cover property (@(negedge LINK_SCL_I) disable iff (!link_rst_n)
		rx_last && kind == K_DEV && !dev_hit);
	c_prog: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) prog_go);

endmodule // spd_eeprom_slave

`default_nettype wire

// ### verification/spd_master_model.sv
/*
 * Behavioural two-wire bus master standing in for the host controller.
 * Assumes the bench resolves SDA as open drain with a pull-up; SCL idles high.
 */
`default_nettype none
module spd_master_model
(
	// Link
	output logic scl_o,
	output logic sda_pull_o,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	// Data moves only in the low phase and is sampled in the middle of the high phase.
	task automatic bit_io(input logic b, output logic s);
		scl_o = 1'b0;
		#8;
		sda_pull_o = ~b;
		#8;
		scl_o = 1'b1;
		#8;
		s = sda_i;
		#8;
	endtask
	task automatic start();
		scl_o = 1'b0;
		#8;
		sda_pull_o = 1'b0;
		#8;
		scl_o = 1'b1;
		#8;
		sda_pull_o = 1'b1;
		#8;
	endtask
	// The trailing low pulse lets the slave settle the stop, then SCL stands still.
	task automatic stop();
		scl_o = 1'b0;
		#8;
		sda_pull_o = 1'b1;
		#8;
		scl_o = 1'b1;
		#8;
		sda_pull_o = 1'b0;
		#8;
		scl_o = 1'b0;
		#16;
		scl_o = 1'b1;
		#16;
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic ack_lvl);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, ack_lvl);
	endtask
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~mack, s);
	endtask
endmodule // spd_master_model
`default_nettype wire

// ### verification/testbench.sv
/*
 * Self-checking bench of the EEPROM slave driven by the host master model.
 * Assumes the design package; SDA is resolved here with a pull-up.
 */
`default_nettype none
module testbench
	import spd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WCYC = 200;
	localparam logic [2:0] STRAP = 3'h5;
	logic clk;
	logic rst_n;
	logic wc_n;
	logic [2:0] strap;
	logic scl;
	logic m_pull;
	logic sda_oe;
	logic sda_out;
	logic standby;
	logic busy;
	wire logic sda = ~(m_pull | (sda_oe & ~sda_out));
	int num_errors = 0;
	int checks = 0;
	int busy_cnt = 0;
	int busy_len = 0;
	logic a;
	logic [7:0] d;
	spd_eeprom_slave #(.WRITE_CYCLE_CYC(WCYC)) spd_eeprom_slave_inst (
		.CLK_SYS_I(clk),
		.RST_N_I(rst_n),
		.LINK_SCL_I(scl),
		.SDA_I(sda),
		.SDA_O(sda_out),
		.SDA_OE_O(sda_oe),
		.WRITE_CTRL_N_I(wc_n),
		.MODULE_ADDR_STRAP_2_I(strap[2]),
		.MODULE_ADDR_STRAP_1_I(strap[1]),
		.MODULE_ADDR_STRAP_0_I(strap[0]),
		.STANDBY_O(standby),
		.PROG_BUSY_O(busy)
	);
	spd_master_model spd_master_model_inst (
		.scl_o(scl),
		.sda_pull_o(m_pull),
		.sda_i(sda)
	);
	initial
	begin
		clk = 1'b0;
		forever
			#2 clk = ~clk;
	end
	// Length of the latest program cycle in system cycles.
	always @(posedge clk)
	begin
		busy_cnt = (busy === 1'b1) ? busy_cnt + 1 : 0;
		if (busy === 1'b1)
			busy_len = busy_cnt;
	end
	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1)
		begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic sel(input logic [3:0] id, input logic rw, input logic exp);
		spd_master_model_inst.start();
		spd_master_model_inst.wr_byte({id, STRAP, rw}, a);
		check(a === exp, "select acknowledge");
	endtask
	task automatic wb(input logic [7:0] b);
		spd_master_model_inst.wr_byte(b, a);
		check(a === 1'b0, "data acknowledge");
	endtask
	task automatic rd(input logic mack, input logic [7:0] exp);
		spd_master_model_inst.rd_byte(mack, d);
		check(d === exp, "read data");
	endtask
	task automatic stp();
		spd_master_model_inst.stop();
		check(standby === 1'b1, "standby after stop");
	endtask
	task automatic rr(input logic [3:0] id, input logic [7:0] addr);
		sel(id, 1'b0, 1'b0);
		wb(addr);
		sel(id, 1'b1, 1'b0);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 2 * WCYC && busy === 1'b1; i++)
			@(negedge clk);
		check(busy === 1'b0, "program cycle ends");
		check(busy_len === WCYC, "program cycle length");
	endtask
	task automatic t_refuse();
		spd_master_model_inst.wr_byte({ID_ARRAY_DEF, STRAP, 1'b0}, a);
		check(a === 1'b1, "byte without start ignored");
		sel(4'h3, 1'b0, 1'b1);
		spd_master_model_inst.wr_byte(8'h00, a);
		check(a === 1'b1, "rest of refused transfer ignored");
		stp();
		@(negedge clk);
		strap = 3'h4;
		sel(ID_ARRAY_DEF, 1'b0, 1'b1);
		stp();
		@(negedge clk);
		strap = STRAP;
	endtask
	task automatic t_write();
		sel(ID_ARRAY_DEF, 1'b0, 1'b0);
		check(standby === 1'b0, "active after start");
		wb(8'h1f);
		wb(8'ha0);
		wb(8'ha1);
		wb(8'ha2);
		stp();
		check(busy === 1'b1, "program cycle starts");
		sel(ID_ARRAY_DEF, 1'b0, 1'b1);
		stp();
		wait_idle();
	endtask
	task automatic t_read();
		rr(ID_ARRAY_DEF, 8'h1f);
		rd(1'b0, 8'ha0);
		stp();
		rr(ID_ARRAY_DEF, 8'h10);
		rd(1'b0, 8'ha1);
		stp();
		sel(ID_ARRAY_DEF, 1'b1, 1'b0);
		rd(1'b0, 8'ha2);
		stp();
		rr(ID_ARRAY_DEF, 8'h10);
		rd(1'b1, 8'ha1);
		rd(1'b0, 8'ha2);
		spd_master_model_inst.bit_io(1'b1, a);
		check(a === 1'b1, "released after no acknowledge");
		check(standby === 1'b0, "standby waits for stop");
		stp();
	endtask
	task automatic t_protect();
		@(negedge clk);
		wc_n = 1'b1;
		sel(ID_ARRAY_DEF, 1'b0, 1'b0);
		wb(8'h10);
		wb(8'h5a);
		stp();
		check(busy === 1'b0, "no program cycle when protected");
		rr(ID_ARRAY_DEF, 8'h10);
		rd(1'b0, 8'ha1);
		stp();
		@(negedge clk);
		wc_n = 1'b0;
		sel(ID_PROT_DEF, 1'b1, 1'b0);
		rd(1'b0, PROT_RST);
		stp();
		sel(ID_PROT_DEF, 1'b0, 1'b0);
		wb(8'h3c);
		wb(8'hc3);
		stp();
		wait_idle();
		sel(ID_PROT_DEF, 1'b1, 1'b0);
		rd(1'b1, 8'hc3);
		rd(1'b0, 8'hc3);
		stp();
	endtask
	task automatic summarize();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		wc_n = 1'b0;
		strap = STRAP;
		repeat (4)
			@(negedge clk);
		rst_n = 1'b1;
		// The link side leaves reset only on SCL falling edges, so it gets dummy clocks.
		repeat (3)
			spd_master_model_inst.bit_io(1'b1, a);
		check(standby === 1'b1 && busy === 1'b0 && sda_oe === 1'b0, "reset state");
		t_refuse();
		t_write();
		t_read();
		t_protect();
		summarize();
	end
	initial
	begin
		#100000;
		num_errors++;
		summarize();
	end
endmodule // testbench
`default_nettype wire
